// ---- core/tmr_cfg.svh ----
// register map, field positions, reset values and divider taps of the 16-bit timer
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// register offsets (byte addresses, one 32-bit word each)
`define TMR_OFS_CTRL 8'h00
`define TMR_OFS_COUNT 8'h04
`define TMR_OFS_CMPA 8'h08
`define TMR_OFS_CMPB 8'h0C
`define TMR_OFS_CAPT 8'h10
`define TMR_OFS_STATUS 8'h14
`define TMR_OFS_MASK 8'h18

// status and mask bit positions
`define TMR_BIT_OVF 0
`define TMR_BIT_CMPA 1
`define TMR_BIT_CMPB 2
`define TMR_BIT_CAPT 3

// reset values
`define TMR_RST_CTRL 11'h000
`define TMR_RST_WORD 16'h0000
`define TMR_RST_FLAGS 4'h0

// counter limits
`define TMR_MAX 16'hFFFF
`define TMR_BOTTOM 16'h0000

// waveform modes handled by the counter
`define TMR_WAVE_NORMAL 4'h0
`define TMR_WAVE_CTC_CMPA 4'h4
`define TMR_WAVE_CTC_CAPT 4'hC

// clock select codes
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7

// prescaler tap masks (divide by mask + 1)
`define TMR_TAP_8 10'h007
`define TMR_TAP_64 10'h03F
`define TMR_TAP_256 10'h0FF
`define TMR_TAP_1024 10'h3FF

`endif

// ---- core/tmr_pkg.sv ----
// types shared by the 16-bit timer core and its prescaler
package tmr_pkg;

    // compare output action on a match (non-pwm modes)
    typedef enum logic [1:0] {
        TMR_ACT_OFF,
        TMR_ACT_TOGGLE,
        TMR_ACT_CLEAR,
        TMR_ACT_SET
    } tmr_act_type;

    // control register layout, msb first
    typedef struct packed {
        tmr_act_type act_b;
        tmr_act_type act_a;
        logic [2:0] clk_sel;
        logic [3:0] waveform_mode_sel;
    } tmr_ctrl_type;

    // sticky event flags, one bit per event
    typedef struct packed {
        logic capt;
        logic cmpb;
        logic cmpa;
        logic ovf;
    } tmr_flags_type;

    // plain register port bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tmr_bus_type;

endpackage

// ---- core/tmr_prescaler.sv ----
// clock select and prescaler producing one-cycle timer tick enables
`timescale 1ns/1ps

module tmr_prescaler
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // selection and synchronised external clock edges
    input wire logic [2:0] clk_sel_in,
    input wire logic ext_rise_in,
    input wire logic ext_fall_in,
    // tick enable
    output logic tick_out
);
`include "tmr_cfg.svh"

    logic [9:0] div_q;
    logic tick_q;
    logic tick_d;

    // true when every bit of the tap is set, i.e. the last cycle of a period
    function automatic logic tap_hit(input logic [9:0] cnt, input logic [9:0] mask);
        tap_hit = (cnt & mask) == mask;
    endfunction

    // free running divider shared by all taps, so a select change never waits long
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_q <= 10'h000;
        end else begin
            div_q <= div_q + 10'h001;
        end
    end

    // select the tick source; stop yields no ticks
    always_comb begin
        unique case (clk_sel_in)
            `TMR_CS_STOP: tick_d = 1'b0;
            `TMR_CS_DIV1: tick_d = 1'b1;
            `TMR_CS_DIV8: tick_d = tap_hit(div_q, `TMR_TAP_8);
            `TMR_CS_DIV64: tick_d = tap_hit(div_q, `TMR_TAP_64);
            `TMR_CS_DIV256: tick_d = tap_hit(div_q, `TMR_TAP_256);
            `TMR_CS_DIV1024: tick_d = tap_hit(div_q, `TMR_TAP_1024);
            `TMR_CS_EXT_FALL: tick_d = ext_fall_in;
            `TMR_CS_EXT_RISE: tick_d = ext_rise_in;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;

endmodule

// ---- core/tmr_core.sv ----
// 16-bit timer/counter core: normal and clear-on-match counting, compare, capture, interrupt
`timescale 1ns/1ps
//
// Contract
// [R1] only waveform mode chooses counting sequence
// [R2] compare action sets, clears or toggles pin
// [R3] mode zero counts up, wraps FFFF to 0000
// [R4] overflow flag set when counter becomes zero; code sets it only on the FFFF wrap, not on a clear or a write
// [R5] servicing overflow interrupt clears overflow flag
// [R6] counter writable any time in normal mode
// [R7] mode 4/12 clear at compare A/capture
// [R8] compare match still raises interrupts in normal
// [R9] software avoids waveform generation in normal mode
// [R10] software keeps capture intervals within counter range
// [R11] at most one step per tick, else hold

module tmr_core (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // register port
    input wire logic [7:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [15:0] RDATA_OUT,
    // interrupt service acknowledge, one bit per flag
    input wire tmr_pkg::tmr_flags_type ACK_IN,
    // pins
    input wire logic EXT_CLK_IN,
    input wire logic CAPTURE_IN,
    output logic OC_A_OUT,
    output logic OC_B_OUT,
    // interrupt
    output logic IRQ_OUT
);
    import tmr_pkg::*;
`include "tmr_cfg.svh"

    tmr_bus_type bus;
    tmr_ctrl_type ctrl_q;
    tmr_flags_type status_q, status_d, mask_q, flag_set, flag_w1c;
    tmr_flags_type mask_d;
    logic [15:0] counter_value_q, counter_value_d;
    logic [15:0] compare_a_value_q, compare_b_value_q, capture_value_q, capture_value_d;
    logic [15:0] rdata_q, rdata_d;
    logic oc_a_q, oc_a_d, oc_b_q, oc_b_d, irq_q;
    logic [2:0] ext_sync_q, capt_sync_q;
    logic tick;

    // stored value for a bus write of a 16-bit register
    function automatic logic [15:0] reg_next(input logic hit, input logic [15:0] wdata, input logic [15:0] cur);
        reg_next = hit ? wdata : cur;
    endfunction

    // pin level after a compare match with the given action
    function automatic logic pin_next(input logic match, input tmr_act_type act, input logic cur);
        pin_next = cur;
        if (match) begin
            unique case (act)
                TMR_ACT_OFF: pin_next = cur;
                TMR_ACT_TOGGLE: pin_next = ~cur;
                TMR_ACT_CLEAR: pin_next = 1'b0;
                TMR_ACT_SET: pin_next = 1'b1;
            endcase
        end
    endfunction

    assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

    // address decode
    wire wr_ctrl = bus.wr && (bus.addr == `TMR_OFS_CTRL);
    wire wr_count = bus.wr && (bus.addr == `TMR_OFS_COUNT);
    wire wr_cmpa = bus.wr && (bus.addr == `TMR_OFS_CMPA);
    wire wr_cmpb = bus.wr && (bus.addr == `TMR_OFS_CMPB);
    wire wr_capt = bus.wr && (bus.addr == `TMR_OFS_CAPT);
    wire wr_status = bus.wr && (bus.addr == `TMR_OFS_STATUS);
    wire wr_mask = bus.wr && (bus.addr == `TMR_OFS_MASK);

    // pin synchronisers: stage 0 is read only by stage 1
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ext_sync_q <= 3'h0;
            capt_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], EXT_CLK_IN};
            capt_sync_q <= {capt_sync_q[1:0], CAPTURE_IN};
        end
    end

    wire ext_rise = ext_sync_q[1] && !ext_sync_q[2];
    wire ext_fall = !ext_sync_q[1] && ext_sync_q[2];
    wire capt_edge = capt_sync_q[1] && !capt_sync_q[2];

    tmr_prescaler u_prescaler (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .clk_sel_in(ctrl_q.clk_sel),
        .ext_rise_in(ext_rise),
        .ext_fall_in(ext_fall),
        .tick_out(tick)
    );

    // top selection depends on the waveform mode alone, never on the compare action
    wire mode_ctc_a = ctrl_q.waveform_mode_sel == `TMR_WAVE_CTC_CMPA; // R7
    wire mode_ctc_i = ctrl_q.waveform_mode_sel == `TMR_WAVE_CTC_CAPT; // R7
    wire at_max = counter_value_q == `TMR_MAX;
    wire match_a = counter_value_q == compare_a_value_q;
    wire match_b = counter_value_q == compare_b_value_q;
    wire match_i = counter_value_q == capture_value_q;
    wire ctc_clear = (mode_ctc_a && match_a) || (mode_ctc_i && match_i); // R7 R1
    // capture register is the top in mode 12, so the pin does not load it there
    wire capt_load = capt_edge && !mode_ctc_i;

    // counter: a software write wins over the tick, one step per tick at most
    always_comb begin
        counter_value_d = counter_value_q; // R11
        if (wr_count) begin
            counter_value_d = bus.wdata; // R6
        end else if (tick && ctc_clear) begin
            counter_value_d = `TMR_BOTTOM; // R7
        end else if (tick) begin
            counter_value_d = counter_value_q + 16'h0001; // R3 R11 R1
        end
    end

    // capture register: the pin edge beats a software write in the same cycle
    assign capture_value_d = capt_load ? counter_value_q : reg_next(wr_capt, bus.wdata, capture_value_q);

    // event sources; the overflow is flagged as the counter wraps from FFFF to zero, not on a clear at the top or a write
    assign flag_set = '{
        capt: capt_load || (tick && !wr_count && mode_ctc_i && match_i),
        cmpb: tick && !wr_count && match_b, // R8
        cmpa: tick && !wr_count && match_a, // R8
        ovf: tick && !wr_count && at_max && !ctc_clear // R4 R3
    };
    assign flag_w1c = wr_status ? tmr_flags_type'(bus.wdata[3:0]) : `TMR_RST_FLAGS;

    // sticky flags: set beats both write-one-clear and interrupt acknowledge
    assign status_d = flag_set | (status_q & ~flag_w1c & ~ACK_IN); // R4 R5

    // compare outputs follow the programmed action on a match
    assign oc_a_d = pin_next(tick && !wr_count && match_a, ctrl_q.act_a, oc_a_q); // R2
    assign oc_b_d = pin_next(tick && !wr_count && match_b, ctrl_q.act_b, oc_b_q); // R2

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 16'h0000;
        unique case (bus.addr)
            `TMR_OFS_CTRL: rdata_d = {5'h00, ctrl_q};
            `TMR_OFS_COUNT: rdata_d = counter_value_q;
            `TMR_OFS_CMPA: rdata_d = compare_a_value_q;
            `TMR_OFS_CMPB: rdata_d = compare_b_value_q;
            `TMR_OFS_CAPT: rdata_d = capture_value_q;
            `TMR_OFS_STATUS: rdata_d = {12'h000, status_q};
            `TMR_OFS_MASK: rdata_d = {12'h000, mask_q};
            default: rdata_d = 16'h0000;
        endcase
        if (!bus.rd) begin
            rdata_d = 16'h0000;
        end
    end

    // next mask, so the interrupt line follows a mask write in the same edge as the register
    assign mask_d = wr_mask ? tmr_flags_type'(bus.wdata[3:0]) : mask_q;

    // configuration and data registers
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ctrl_q <= `TMR_RST_CTRL;
            mask_q <= `TMR_RST_FLAGS;
            compare_a_value_q <= `TMR_RST_WORD;
            compare_b_value_q <= `TMR_RST_WORD;
            capture_value_q <= `TMR_RST_WORD;
        end else begin
            ctrl_q <= wr_ctrl ? tmr_ctrl_type'(bus.wdata[10:0]) : ctrl_q;
            mask_q <= mask_d;
            compare_a_value_q <= reg_next(wr_cmpa, bus.wdata, compare_a_value_q);
            compare_b_value_q <= reg_next(wr_cmpb, bus.wdata, compare_b_value_q);
            capture_value_q <= capture_value_d;
        end
    end

    // counting state, flags, pins and bus answer
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            counter_value_q <= `TMR_RST_WORD;
            status_q <= `TMR_RST_FLAGS;
            oc_a_q <= 1'b0;
            oc_b_q <= 1'b0;
            rdata_q <= `TMR_RST_WORD;
            irq_q <= 1'b0;
        end else begin
            counter_value_q <= counter_value_d;
            status_q <= status_d;
            oc_a_q <= oc_a_d;
            oc_b_q <= oc_b_d;
            rdata_q <= rdata_d;
            irq_q <= |(status_d & mask_d); // registered so the pin comes from a flop
        end
    end

    assign RDATA_OUT = rdata_q;
    assign OC_A_OUT = oc_a_q;
    assign OC_B_OUT = oc_b_q;
    assign IRQ_OUT = irq_q;

    // checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    wire step_ok = tick && !wr_count && !ctc_clear;

    a_normal_wrap: assert property ( // R3
        (ctrl_q.waveform_mode_sel == `TMR_WAVE_NORMAL) && step_ok && at_max |=> counter_value_q == `TMR_BOTTOM
    ) else $error("counter did not wrap to zero");
    a_ovf_on_zero: assert property ( // R4
        step_ok && at_max |=> status_q.ovf && (counter_value_q == `TMR_BOTTOM)
    ) else $error("overflow flag not set as counter became zero");
    a_ovf_sticky: assert property ( // R4
        status_q.ovf && !ACK_IN.ovf && !(wr_status && bus.wdata[`TMR_BIT_OVF]) |=> status_q.ovf
    ) else $error("overflow flag cleared without a clear");
    a_ovf_service: assert property ( // R5
        ACK_IN.ovf && !flag_set.ovf |=> !status_q.ovf
    ) else $error("service did not clear overflow flag");
    a_count_write: assert property ( // R6
        wr_count |=> counter_value_q == $past(bus.wdata)
    ) else $error("counter write lost");
    a_ctc_clear: assert property ( // R7
        tick && !wr_count && (mode_ctc_a && match_a || mode_ctc_i && match_i) |=> counter_value_q == `TMR_BOTTOM
    ) else $error("counter not cleared at top");
    a_cmp_flag: assert property ( // R8
        tick && !wr_count && match_a |=> status_q.cmpa
    ) else $error("compare A flag missing");
    a_one_step: assert property ( // R11
        step_ok |=> counter_value_q == $past(counter_value_q) + 16'h0001
    ) else $error("counter did not advance by one");
    a_hold_idle: assert property ( // R11
        !tick && !wr_count |=> $stable(counter_value_q)
    ) else $error("counter moved without a tick");
    a_pin_toggle: assert property ( // R2
        tick && !wr_count && match_a && ctrl_q.act_a == TMR_ACT_TOGGLE |=> OC_A_OUT != $past(OC_A_OUT)
    ) else $error("compare pin did not toggle");
    a_irq_level: assert property (
        IRQ_OUT == |(status_q & mask_q)
    ) else $error("interrupt output does not follow flags");

    // compare pins move only on a match, with the programmed action
    a_pin_set: assert property ( // R2
        tick && !wr_count && match_a && ctrl_q.act_a == TMR_ACT_SET |=> OC_A_OUT
    ) else $error("compare pin A not set on match");
    a_pin_clear: assert property ( // R2
        tick && !wr_count && match_a && ctrl_q.act_a == TMR_ACT_CLEAR |=> !OC_A_OUT
    ) else $error("compare pin A not cleared on match");
    a_pin_b_set: assert property ( // R2
        tick && !wr_count && match_b && ctrl_q.act_b == TMR_ACT_SET |=> OC_B_OUT
    ) else $error("compare pin B not set on match");
    a_pin_a_hold: assert property ( // R2
        !(tick && !wr_count && match_a) |=> $stable(OC_A_OUT)
    ) else $error("compare pin A moved without a match");
    a_pin_b_hold: assert property ( // R2
        !(tick && !wr_count && match_b) |=> $stable(OC_B_OUT)
    ) else $error("compare pin B moved without a match");

    // counting ignores the compare units outside clear-on-match modes
    a_match_no_clear: assert property ( // R1
        (ctrl_q.waveform_mode_sel == `TMR_WAVE_NORMAL) && tick && !wr_count && match_a && !at_max
            |=> counter_value_q == $past(counter_value_q) + 16'h0001
    ) else $error("compare match disturbed normal counting");

    // flags: counting only sets them, software or service clears them
    a_ovf_set_only: assert property ( // R4
        !status_q.ovf && !(tick && !wr_count && at_max) |=> !status_q.ovf
    ) else $error("overflow flag set away from the wrap");
    a_ovf_w1c: assert property (
        wr_status && bus.wdata[`TMR_BIT_OVF] && !flag_set.ovf |=> !status_q.ovf
    ) else $error("write-one did not clear overflow flag");
    a_cmpb_flag: assert property ( // R8
        tick && !wr_count && match_b |=> status_q.cmpb
    ) else $error("compare B flag missing");
    a_top_flag: assert property ( // R7
        tick && !wr_count && mode_ctc_i && match_i |=> status_q.capt
    ) else $error("capture-register top did not raise its flag");

    // capture loads the count; the top register is kept in mode 12
    a_capt_load: assert property (
        capt_load |=> capture_value_q == $past(counter_value_q) && status_q.capt
    ) else $error("capture edge did not load the count");
    a_capt_top_kept: assert property ( // R7
        mode_ctc_i && !wr_capt |=> $stable(capture_value_q)
    ) else $error("capture register moved while it is the top");

    // stopped clock gives no tick; an idle bus reads zero
    a_stop_no_tick: assert property ( // R11
        ctrl_q.clk_sel == `TMR_CS_STOP |=> !tick
    ) else $error("tick seen with the clock stopped");
    a_rdata_idle: assert property (
        !bus.rd |=> RDATA_OUT == 16'h0000
    ) else $error("read data outside its cycle");

    c_overflow: cover property (step_ok && at_max ##1 IRQ_OUT);
    c_ctc_top: cover property (tick && mode_ctc_a && match_a ##1 counter_value_q == `TMR_BOTTOM);
    c_capture: cover property (capt_load ##1 status_q.capt);
    c_set_wins: cover property (flag_set.ovf && ACK_IN.ovf);
    c_ext_tick: cover property (ctrl_q.clk_sel == `TMR_CS_EXT_RISE && tick);

endmodule

// ---- sim/test_tmr_core.sv ----
// self-checking bench for the 16-bit timer core: normal, clear-on-match, flags and interrupt
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module test_tmr_core;
    import tmr_pkg::*;

    logic CLK_IN = 1'b0;
    logic RESET_IN = 1'b1;
    logic [7:0] ADDR_IN = 8'h00;
    logic [15:0] WDATA_IN = 16'h0000;
    logic WR_IN = 1'b0;
    logic RD_IN = 1'b0;
    logic [15:0] RDATA_OUT;
    tmr_flags_type ACK_IN = 4'h0;
    logic EXT_CLK_IN = 1'b0;
    logic CAPTURE_IN = 1'b0;
    logic OC_A_OUT;
    logic OC_B_OUT;
    logic IRQ_OUT;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    logic [15:0] d0;
    logic [15:0] d1;
    logic exp_oc;
    int top;
    int i;
    int k;
    int n;
    int t0;
    int t1;
    logic [7:0] ra;
    logic [15:0] exp_q[$];
    tmr_ctrl_type cfg;

    tmr_core u_dut (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
        .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .ACK_IN(ACK_IN), .EXT_CLK_IN(EXT_CLK_IN),
        .CAPTURE_IN(CAPTURE_IN), .OC_A_OUT(OC_A_OUT), .OC_B_OUT(OC_B_OUT), .IRQ_OUT(IRQ_OUT));

    // 125 MHz clock
    always #4 CLK_IN = ~CLK_IN;

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge CLK_IN) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        WDATA_IN <= d;
        WR_IN <= 1'b1;
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
    endtask

    // one read; data stands only in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        @(negedge CLK_IN);
        d = RDATA_OUT;
    endtask

    // two reads of one address on consecutive edges
    task automatic rd2(input logic [7:0] a, output logic [15:0] x, output logic [15:0] y);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CLK_IN);
        @(negedge CLK_IN);
        x = RDATA_OUT;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        @(negedge CLK_IN);
        y = RDATA_OUT;
    endtask

    task automatic ctrl(input tmr_act_type act, input logic [2:0] cs, input logic [3:0] mode);
        tmr_ctrl_type c;
        c = '{act_b: TMR_ACT_OFF, act_a: act, clk_sel: cs, waveform_mode_sel: mode};
        wr(`TMR_OFS_CTRL, {5'h00, c});
    endtask

    task automatic wait_irq(input int lim);
        for (int n = 0; n < lim && IRQ_OUT !== 1'b1; n++) begin
            @(posedge CLK_IN);
        end
        @(negedge CLK_IN);
    endtask

    // main sequence
    initial begin
        void'($urandom(32'hA757));
        repeat (8) @(posedge CLK_IN);
        RESET_IN <= 1'b0;
        // reset values, unmapped address included
        for (i = 0; i < 8; i++) begin
            rd(8'(i * 4), d0);
            check(d0, 16'h0000);
            check({15'h0000, IRQ_OUT}, 16'h0000);
        end
        @(negedge CLK_IN);
        check(RDATA_OUT, 16'h0000);
        // random words through the register model; the mask keeps only its four bits
        for (i = 0; i < 6; i++) begin
            ra = (i % 3 == 0) ? `TMR_OFS_CMPB : (i % 3 == 1) ? `TMR_OFS_CAPT : `TMR_OFS_MASK;
            d0 = 16'($urandom);
            exp_q.push_back((ra == `TMR_OFS_MASK) ? {12'h000, d0[3:0]} : d0);
            wr(ra, d0);
            rd(ra, d1);
            check(d1, exp_q.pop_front());
        end
        // stopped counter takes a write and holds it
        wr(`TMR_OFS_COUNT, 16'hFFF0 + 16'($urandom % 8));
        rd2(`TMR_OFS_COUNT, d0, d1);
        check(d1, d0);
        check({12'h000, d0[15:4]}, 16'h0FFF);
        // normal mode wraps past the top and raises the overflow flag
        wr(`TMR_OFS_MASK, 16'h0001);
        ctrl(TMR_ACT_OFF, `TMR_CS_DIV1, `TMR_WAVE_NORMAL);
        wait_irq(60);
        check({15'h0000, IRQ_OUT}, 16'h0001);
        rd2(`TMR_OFS_COUNT, d0, d1);
        check({15'h0000, d0 < 16'h0040}, 16'h0001);
        check(d1, d0 + 16'h0001);
        rd(`TMR_OFS_STATUS, d0);
        check(d0 & 16'h0001, 16'h0001);
        // interrupt service clears the overflow flag
        @(posedge CLK_IN);
        ACK_IN <= 4'h1;
        @(posedge CLK_IN);
        ACK_IN <= 4'h0;
        rd(`TMR_OFS_STATUS, d0);
        check(d0 & 16'h0001, 16'h0000);
        check({15'h0000, IRQ_OUT}, 16'h0000);
        // write while running
        wr(`TMR_OFS_COUNT, 16'h1234);
        rd(`TMR_OFS_COUNT, d0);
        check({15'h0000, d0 >= 16'h1234 && d0 <= 16'h1237}, 16'h0001);
        // compare actions in normal mode; counting must ignore them; one match each, no waveform
        exp_oc = 1'b0;
        for (k = 0; k < 4; k++) begin
            ctrl(TMR_ACT_OFF, `TMR_CS_STOP, `TMR_WAVE_NORMAL);
            wr(`TMR_OFS_STATUS, 16'h000F);
            wr(`TMR_OFS_MASK, 16'h0002);
            wr(`TMR_OFS_COUNT, 16'h0008);
            wr(`TMR_OFS_CMPA, 16'h0010);
            case (k)
                0: begin
                    ctrl(TMR_ACT_SET, `TMR_CS_DIV1, `TMR_WAVE_NORMAL);
                    exp_oc = 1'b1;
                end
                1: begin
                    ctrl(TMR_ACT_CLEAR, `TMR_CS_DIV1, `TMR_WAVE_NORMAL);
                    exp_oc = 1'b0;
                end
                default: begin
                    ctrl(TMR_ACT_TOGGLE, `TMR_CS_DIV1, `TMR_WAVE_NORMAL);
                    exp_oc = ~exp_oc;
                end
            endcase
            wait_irq(100);
            check({15'h0000, IRQ_OUT}, 16'h0001);
            repeat (4) @(posedge CLK_IN);
            ctrl(TMR_ACT_OFF, `TMR_CS_STOP, `TMR_WAVE_NORMAL);
            check({15'h0000, OC_A_OUT}, {15'h0000, exp_oc});
            rd(`TMR_OFS_COUNT, d0);
            check({15'h0000, d0 > 16'h0011}, 16'h0001);
            rd(`TMR_OFS_STATUS, d0);
            check(d0 & 16'h0002, 16'h0002);
        end
        // clear on match with a random top, compare A then capture register
        wr(`TMR_OFS_MASK, 16'h0000);
        for (k = 0; k < 2; k++) begin
            top = 3 + ($urandom % 13);
            wr(`TMR_OFS_STATUS, 16'h000F);
            wr(`TMR_OFS_COUNT, 16'h0000);
            wr(`TMR_OFS_CMPA, (k == 0) ? 16'(top) : 16'hFFFF);
            wr(`TMR_OFS_CAPT, (k == 0) ? 16'hFFFF : 16'(top));
            ctrl(TMR_ACT_OFF, `TMR_CS_DIV1, (k == 0) ? `TMR_WAVE_CTC_CMPA : `TMR_WAVE_CTC_CAPT);
            for (i = 0; i < 12; i++) begin
                rd2(`TMR_OFS_COUNT, d0, d1);
                check({15'h0000, d0 <= 16'(top)}, 16'h0001);
                check(d1, (d0 == 16'(top)) ? 16'h0000 : d0 + 16'h0001);
            end
            ctrl(TMR_ACT_OFF, `TMR_CS_STOP, `TMR_WAVE_NORMAL);
            rd(`TMR_OFS_STATUS, d0);
            check(d0 & 16'h0009, (k == 0) ? 16'h0000 : 16'h0008);
            check({15'h0000, IRQ_OUT}, 16'h0000);
        end
        // external clock on rising then falling pin edges, one step per edge
        for (k = 0; k < 2; k++) begin
            n = 2 + ($urandom % 6);
            wr(`TMR_OFS_COUNT, 16'h0000);
            ctrl(TMR_ACT_OFF, (k == 0) ? `TMR_CS_EXT_RISE : `TMR_CS_EXT_FALL, `TMR_WAVE_NORMAL);
            for (i = 0; i < n; i++) begin
                @(posedge CLK_IN);
                EXT_CLK_IN <= 1'b1;
                repeat (3) @(posedge CLK_IN);
                EXT_CLK_IN <= 1'b0;
                repeat (2) @(posedge CLK_IN);
            end
            repeat (6) @(posedge CLK_IN);
            rd(`TMR_OFS_COUNT, d0);
            check(d0, 16'(n));
        end
        ctrl(TMR_ACT_OFF, `TMR_CS_STOP, `TMR_WAVE_NORMAL);
        // capture interval and compare B in normal mode; events stay well inside the counter range
        wr(`TMR_OFS_STATUS, 16'h000F);
        wr(`TMR_OFS_COUNT, 16'h0000);
        wr(`TMR_OFS_CMPB, 16'h0030);
        wr(`TMR_OFS_MASK, 16'h0008);
        cfg = '{act_b: TMR_ACT_SET, act_a: TMR_ACT_OFF, clk_sel: `TMR_CS_DIV1,
            waveform_mode_sel: `TMR_WAVE_NORMAL};
        wr(`TMR_OFS_CTRL, {5'h00, cfg});
        for (i = 0; i < 2; i++) begin
            @(posedge CLK_IN);
            CAPTURE_IN <= 1'b1;
            t1 = t0;
            t0 = cycles;
            repeat (2) @(posedge CLK_IN);
            CAPTURE_IN <= 1'b0;
            repeat (6) @(posedge CLK_IN);
            d1 = d0;
            rd(`TMR_OFS_CAPT, d0);
        end
        check(d0 - d1, 16'(t0 - t1));
        check({15'h0000, IRQ_OUT}, 16'h0001);
        check({15'h0000, OC_B_OUT}, 16'h0000);
        repeat (40) @(posedge CLK_IN);
        check({15'h0000, OC_B_OUT}, 16'h0001);
        rd(`TMR_OFS_STATUS, d0);
        check(d0 & 16'h000C, 16'h000C);
        complete_run();
    end
endmodule
